// ---- inc/tfpv_consts.svh ----
`ifndef TFPV_CONSTS_SVH
`define TFPV_CONSTS_SVH
// Register byte offsets
`define TFPV_OFS_CTRL 8'h00
`define TFPV_OFS_STATUS 8'h04
`define TFPV_OFS_BUTTON 8'h08
`define TFPV_OFS_FAULTCNT 8'h0c
`define TFPV_OFS_CHGCNT 8'h10
`define TFPV_OFS_PARAM 8'h14
// Control bit positions
`define TFPV_CTRL_USER1 0
`define TFPV_CTRL_USER2 1
`define TFPV_CTRL_UNLOCK 2
`define TFPV_CTRL_FRST 3
// Status bit positions
`define TFPV_STAT_VERR 0
`define TFPV_STAT_MISM 1
`define TFPV_STAT_TPASS 4
`define TFPV_STAT_TFAIL 5
`define TFPV_STAT_KEYRUN 6
`define TFPV_STAT_ACTIVE 7
// Reset values
`define TFPV_CTRL_RST 4'h0
`define TFPV_PARAM_RST 32'h0000_0000
// Timing
`define TFPV_CLK_PERIOD_NS 10
`define TFPV_BLINK_PERIOD_MS 1000
`define TFPV_DEBOUNCE_MS 5
`define TFPV_NS_PER_MS 1000000
`define TFPV_BLINK_HALF \
    ((`TFPV_BLINK_PERIOD_MS * `TFPV_NS_PER_MS / `TFPV_CLK_PERIOD_NS) / 2)
`define TFPV_DEBOUNCE_CYC \
    (`TFPV_DEBOUNCE_MS * `TFPV_NS_PER_MS / `TFPV_CLK_PERIOD_NS)
`define TFPV_TEST_STEPS 4
`endif

// ---- inc/tfpv_pkg.sv ----
package tfpv_pkg;
    typedef enum logic [1:0]
    {
        TFPV_ST_INIT = 2'h0,
        TFPV_ST_TEST = 2'h1,
        TFPV_ST_RUN = 2'h3,
        TFPV_ST_FAIL = 2'h2
    } tfpv_state_t;
    // Status word each slice sends to the panel voter
    typedef struct packed {
        logic active;
        logic standby;
        logic educated;
        logic educating;
        logic app_run;
        logic full_integ;
        logic ch_locked;
        logic sys_fault;
    } tfpv_stat_t;
    typedef struct packed {
        logic green;
        logic red;
    } tfpv_led_t;
    typedef struct packed {
        tfpv_led_t [2:0] health;
        tfpv_led_t active;
        tfpv_led_t standby;
        tfpv_led_t educated;
        tfpv_led_t run;
        tfpv_led_t inhibit;
        tfpv_led_t sys_ok;
        tfpv_led_t user2;
        tfpv_led_t user1;
    } tfpv_panel_t;
    // Operator controls, raw from the pins
    typedef struct packed {
        logic [1:0] latch;
        logic key_run;
        logic btn;
    } tfpv_sw_t;
endpackage

// ---- verilog/tfpv_voter.sv ----
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "tfpv_consts.svh"
// How it works
// - Power-up self-test of voter and detector before normal running.
// - Data copies from three slices are voted two of three, continuously.
// - A disagreeing copy is outvoted and the sticky error flag set.
// - Panel status bits are voted two of three before driving LEDs.
// - Eleven LEDs: three health, active, standby, educated, run, inhibit...
// - Each health LED follows its own slice: green ok, red failed.
// - Active LED steady green in active mode, else off.
// - Standby LED steady green; flashes after dropping from active.
// - Educated LED steady when educated, flashes while educating, both only while app_run is set.
// - Run LED flashes in full-integrity run, steady in standby.
// - Inhibit LED flashes on locked channel or refused changeover.
// - System LED green when healthy, flashing red on any fault.
// - Two red user LEDs set only by software.
// - Slice flashing red forces changeover to standby module.
// - Fault reset clears faults and the fault counter and asks others too.
// - Either latch switch raises an interrupt to all three slices.
// - Opening ejectors with a standby present triggers changeover.
// - Each changeover is bumpless and logged as an event.
// - Only the active module starts the standby's promotion.
// - Run key position locks parameter memory against writes.
// - Button reads as one-shot true per press; key true means run.
module tfpv_voter
#(
    parameter int DW = 32,
    parameter int BLINK_HALF = `TFPV_BLINK_HALF,
    parameter int DEB_CYC = `TFPV_DEBOUNCE_CYC
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [DW-1:0] link_data_a,
    input wire logic [DW-1:0] link_data_b,
    input wire logic [DW-1:0] link_data_c,
    input wire tfpv_pkg::tfpv_stat_t stat_a,
    input wire tfpv_pkg::tfpv_stat_t stat_b,
    input wire tfpv_pkg::tfpv_stat_t stat_c,
    input wire logic [2:0] slice_ok,
    input wire logic [2:0] slice_fatal,
    input wire tfpv_pkg::tfpv_sw_t sw_pins,
    input wire logic standby_present,
    input wire logic standby_cfg_same,
    output logic [DW-1:0] voted_data,
    output logic vote_error,
    output tfpv_pkg::tfpv_panel_t panel,
    output logic [2:0] proc_irq,
    output logic fault_reset_req,
    output logic changeover_req,
    output logic chg_event,
    output logic unlock_pulse,
    output logic mem_wr_lock,
    output logic selftest_ok
);
    ////////////////////////////////////////////////////////////////////
    // Two of three helpers
    function automatic logic [DW-1:0] vote3(input logic [DW-1:0] a,
        input logic [DW-1:0] b, input logic [DW-1:0] c);
        return (a & b) | (a & c) | (b & c);
    endfunction

    function automatic logic [2:0] odd_one(input logic [DW-1:0] a,
        input logic [DW-1:0] b, input logic [DW-1:0] c);
        logic [DW-1:0] v;
        v = vote3(a, b, c);
        return {c != v, b != v, a != v};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Switch synchronisers and debouncers
    localparam int DBW = $clog2(DEB_CYC + 1);
    logic [3:0] sw_raw;
    logic [3:0] sw_db_ff;
    logic [3:0] sw_prev_ff;
    assign sw_raw = sw_pins;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_sw
            logic [2:0] sync_ff;
            logic [DBW-1:0] cnt_ff;
            logic db_ff;
            // One driver per stage; the vector only gathers the bits
            assign sw_db_ff[gi] = db_ff;
            // Three stages; only the last two are compared
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    sync_ff <= 3'h0;
                else if (clk_en)
                    sync_ff <= {sync_ff[1:0], sw_raw[gi]};
            end
            // Level must stand DEB_CYC cycles before it is accepted
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    cnt_ff <= '0;
                    db_ff <= 1'b0;
                end
                else if (clk_en)
                begin
                    if (sync_ff[1] != sync_ff[2]
                        || sync_ff[2] == db_ff)
                        cnt_ff <= '0;
                    else if (cnt_ff == DBW'(DEB_CYC - 1))
                    begin
                        cnt_ff <= '0;
                        db_ff <= sync_ff[2];
                    end
                    else
                        cnt_ff <= cnt_ff + 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sw_prev_ff <= 4'h0;
        else if (clk_en)
            sw_prev_ff <= sw_db_ff;
    end

    logic btn_press;
    logic latch_open;
    logic key_run;
    assign btn_press = sw_db_ff[0] & ~sw_prev_ff[0];
    assign key_run = sw_db_ff[1];
    assign latch_open = |(sw_db_ff[3:2] & ~sw_prev_ff[3:2]);
    assign mem_wr_lock = key_run;

    ////////////////////////////////////////////////////////////////////
    // Shared blink wave
    localparam int BKW = $clog2(BLINK_HALF + 1);
    logic [BKW-1:0] blink_cnt_ff;
    logic blink_ff;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            blink_cnt_ff <= '0;
            blink_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (blink_cnt_ff == BKW'(BLINK_HALF - 1))
            begin
                blink_cnt_ff <= '0;
                blink_ff <= ~blink_ff;
            end
            else
                blink_cnt_ff <= blink_cnt_ff + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Power-up self-test: voter and detector on known patterns
    tfpv_pkg::tfpv_state_t st_ff;
    logic [1:0] step_ff;
    logic [DW-1:0] pat;
    logic test_bad;
    assign pat = DW'({16{step_ff}});
    assign test_bad = vote3(pat, pat, ~pat) != pat
        || vote3(~pat, pat, pat) != pat
        || odd_one(~pat, pat, pat) != 3'h1
        || odd_one(pat, pat, pat) != 3'h0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff <= tfpv_pkg::TFPV_ST_INIT;
            step_ff <= 2'h0;
        end
        else if (clk_en)
        begin
            unique case (st_ff)
                tfpv_pkg::TFPV_ST_INIT:
                    st_ff <= tfpv_pkg::TFPV_ST_TEST;
                tfpv_pkg::TFPV_ST_TEST:
                begin
                    step_ff <= step_ff + 2'h1;
                    if (test_bad)
                        st_ff <= tfpv_pkg::TFPV_ST_FAIL;
                    else if (32'(step_ff) == `TFPV_TEST_STEPS - 1)
                        st_ff <= tfpv_pkg::TFPV_ST_RUN;
                end
                tfpv_pkg::TFPV_ST_RUN:
                    st_ff <= tfpv_pkg::TFPV_ST_RUN;
                tfpv_pkg::TFPV_ST_FAIL:
                    st_ff <= tfpv_pkg::TFPV_ST_FAIL;
            endcase
        end
    end
    logic running;
    assign running = st_ff == tfpv_pkg::TFPV_ST_RUN;
    assign selftest_ok = running;

    ////////////////////////////////////////////////////////////////////
    // Data and status voting
    logic [2:0] mism;
    tfpv_pkg::tfpv_stat_t vs;
    assign mism = odd_one(link_data_a, link_data_b, link_data_c);
    assign vs = 8'(vote3(DW'(stat_a), DW'(stat_b), DW'(stat_c)));

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            voted_data <= '0;
        else if (clk_en)
            voted_data <= vote3(link_data_a, link_data_b,
                link_data_c);
    end

    ////////////////////////////////////////////////////////////////////
    // Register bus address phase
    logic ap_take;
    logic ap_wr_ff;
    logic [7:0] ap_addr_ff;
    logic [3:0] ctrl_ff;
    logic [31:0] param_ff;
    logic [15:0] fault_cnt_ff;
    logic [15:0] chg_cnt_ff;
    logic [2:0] mism_ff;
    logic btn_shot_ff;
    logic wr_ctrl;
    logic sw_frst;
    logic fault_clr;
    logic rd_btn;
    assign hreadyout = clk_en; // Stall while frozen
    assign hresp = 1'b0;
    assign ap_take = hsel & htrans[1] & hready & clk_en;
    assign rd_btn = ap_take & ~hwrite
        & haddr[7:0] == `TFPV_OFS_BUTTON;
    assign wr_ctrl = ap_wr_ff & ap_addr_ff == `TFPV_OFS_CTRL & clk_en;
    assign sw_frst = wr_ctrl & hwdata[`TFPV_CTRL_FRST];
    assign fault_clr = btn_press | sw_frst;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_wr_ff <= 1'b0;
            ap_addr_ff <= 8'h00;
        end
        else if (clk_en)
        begin
            ap_wr_ff <= ap_take & hwrite;
            ap_addr_ff <= haddr[7:0];
        end
    end

    // Read data is fetched in the address phase, shown in data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (ap_take & ~hwrite)
        begin
            unique case (haddr[7:0])
                `TFPV_OFS_CTRL: hrdata <= {29'h0, ctrl_ff[2:0]};
                `TFPV_OFS_STATUS: hrdata <= {24'h0, vs.active, key_run,
                    st_ff == tfpv_pkg::TFPV_ST_FAIL, running,
                    mism_ff, vote_error};
                `TFPV_OFS_BUTTON: hrdata <= {31'h0, btn_shot_ff};
                `TFPV_OFS_FAULTCNT: hrdata <= {16'h0, fault_cnt_ff};
                `TFPV_OFS_CHGCNT: hrdata <= {16'h0, chg_cnt_ff};
                `TFPV_OFS_PARAM: hrdata <= param_ff;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Control, unlock edge and the locked parameter word
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_ff <= `TFPV_CTRL_RST;
            unlock_pulse <= 1'b0;
            param_ff <= `TFPV_PARAM_RST;
        end
        else if (clk_en)
        begin
            unlock_pulse <= wr_ctrl & hwdata[`TFPV_CTRL_UNLOCK]
                & ~ctrl_ff[`TFPV_CTRL_UNLOCK];
            if (wr_ctrl)
                ctrl_ff <= {1'b0, hwdata[2:0]};
            if (ap_wr_ff & ap_addr_ff == `TFPV_OFS_PARAM & ~key_run)
                param_ff <= hwdata;
        end
    end

    // Press flag: a new press beats the clear by a read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            btn_shot_ff <= 1'b0;
        else if (clk_en)
            btn_shot_ff <= btn_press | (btn_shot_ff & ~rd_btn);
    end

    ////////////////////////////////////////////////////////////////////
    // Fault record; a mismatch in the clear cycle is kept
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            vote_error <= 1'b0;
            mism_ff <= 3'h0;
            fault_cnt_ff <= 16'h0000;
            fault_reset_req <= 1'b0;
        end
        else if (clk_en)
        begin
            fault_reset_req <= fault_clr;
            vote_error <= |mism | (vote_error & ~fault_clr);
            mism_ff <= mism | (mism_ff & {3{~fault_clr}});
            if (|mism)
                fault_cnt_ff <= (fault_clr ? 16'h0000 : fault_cnt_ff)
                    + 16'(fault_cnt_ff != 16'hffff || fault_clr);
            else if (fault_clr)
                fault_cnt_ff <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Latch interrupts and changeover
    logic chg_trig;
    logic chg_trig_q_ff;
    logic cfg_block_ff;
    logic demoted_ff;
    logic active_q_ff;
    assign chg_trig = running & vs.active & standby_present
        & (|slice_fatal | latch_open);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            proc_irq <= 3'h0;
        else if (clk_en)
            proc_irq <= {3{latch_open}};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            chg_trig_q_ff <= 1'b0;
            changeover_req <= 1'b0;
            chg_event <= 1'b0;
            chg_cnt_ff <= 16'h0000;
            cfg_block_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            chg_trig_q_ff <= chg_trig;
            changeover_req <= chg_trig & ~chg_trig_q_ff
                & standby_cfg_same;
            chg_event <= chg_trig & ~chg_trig_q_ff
                & standby_cfg_same;
            if (chg_trig & ~chg_trig_q_ff & standby_cfg_same)
                chg_cnt_ff <= chg_cnt_ff + 16'h0001;
            cfg_block_ff <= (chg_trig & ~standby_cfg_same)
                | (cfg_block_ff & ~fault_clr);
        end
    end

    // Remember a drop from active so standby LED can flash
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            active_q_ff <= 1'b0;
            demoted_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            active_q_ff <= vs.active;
            if (vs.active)
                demoted_ff <= 1'b0;
            else if (active_q_ff & vs.standby)
                demoted_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Panel LEDs, registered so they never glitch
    logic sys_bad;
    assign sys_bad = ~running | vs.sys_fault | vote_error
        | ~&slice_ok;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            panel <= '0;
        else if (clk_en)
        begin
            for (int i = 0; i < 3; i++)
            begin
                panel.health[i].green <= slice_ok[i];
                panel.health[i].red <= ~slice_ok[i]
                    & (~slice_fatal[i] | blink_ff);
            end
            panel.active <= '{green: vs.active, red: 1'b0};
            panel.standby <= '{green: vs.standby
                & (~demoted_ff | blink_ff), red: 1'b0};
            panel.educated <= '{green: vs.app_run & (vs.educated
                | (vs.educating & blink_ff)), red: 1'b0};
            panel.run <= '{green: vs.standby | (vs.active & vs.app_run
                & vs.full_integ & blink_ff), red: 1'b0};
            panel.inhibit <= '{green: (vs.ch_locked | cfg_block_ff)
                & blink_ff, red: 1'b0};
            panel.sys_ok <= '{green: ~sys_bad,
                red: sys_bad & blink_ff};
            panel.user1 <= '{green: 1'b0,
                red: ctrl_ff[`TFPV_CTRL_USER1]};
            panel.user2 <= '{green: 1'b0,
                red: ctrl_ff[`TFPV_CTRL_USER2]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    vote_majority_a: assert property (
        clk_en && link_data_a == link_data_b
        |=> voted_data == $past(link_data_a))
        else $error("voted data lost the agreeing pair");
    vote_error_a: assert property (
        clk_en && link_data_a != link_data_b |=> vote_error)
        else $error("mismatch did not set the error flag");
    latch_irq_a: assert property (
        clk_en && latch_open |=> proc_irq == 3'h7 ##1 proc_irq == 3'h0
        || !$past(clk_en))
        else $error("latch interrupt not one pulse to all slices");
    chg_log_a: assert property (
        changeover_req && $past(clk_en) |-> chg_event
        && chg_cnt_ff == $past(chg_cnt_ff) + 16'h0001)
        else $error("changeover not logged");
    param_lock_a: assert property (
        clk_en && ap_wr_ff && key_run |=> $stable(param_ff))
        else $error("parameter written in run position");
    unlock_edge_a: assert property (
        unlock_pulse && $past(clk_en)
        |-> $past(ctrl_ff[`TFPV_CTRL_UNLOCK]) == 1'b0)
        else $error("unlock fired without a rising edge");
    fault_clear_a: assert property (
        clk_en && fault_clr && mism == 3'h0
        |=> fault_cnt_ff == 16'h0000 && !vote_error && fault_reset_req)
        else $error("fault reset did not clear the record");
    active_led_a: assert property (
        clk_en ##1 1'b1 |-> panel.active.green == $past(vs.active))
        else $error("active LED does not follow mode");
    test_first_a: assert property (
        running |-> $past(st_ff, 1) inside
        {tfpv_pkg::TFPV_ST_TEST, tfpv_pkg::TFPV_ST_RUN})
        else $error("normal running without self-test");
endmodule // tfpv_voter

// ---- sim/tfpv_slice_model.sv ----
`timescale 1ns/1ps
// Three lockstep slices facing the voter; a faulty copy is fully inverted
module tfpv_slice_model
#(
    parameter int DW = 32
)
(
    input wire logic hclk,
    input wire logic [DW-1:0] word,
    input wire logic [2:0] bad,
    input wire tfpv_pkg::tfpv_stat_t stat,
    input wire logic [2:0] stat_bad,
    output logic [DW-1:0] data_a,
    output logic [DW-1:0] data_b,
    output logic [DW-1:0] data_c,
    output tfpv_pkg::tfpv_stat_t st_a,
    output tfpv_pkg::tfpv_stat_t st_b,
    output tfpv_pkg::tfpv_stat_t st_c
);
    // Known levels before the first edge so the voter never sees unknowns
    initial
    begin
        {data_a, data_b, data_c} = '0;
        {st_a, st_b, st_c} = '0;
    end
    // Slices change just after the edge; inverting every bit of a bad copy
    // makes a single flipped bit in the vote impossible to hide
    always @(posedge hclk)
    begin
        data_a <= bad[0] ? ~word : word;
        data_b <= bad[1] ? ~word : word;
        data_c <= bad[2] ? ~word : word;
        st_a <= stat_bad[0] ? ~stat : stat;
        st_b <= stat_bad[1] ? ~stat : stat;
        st_c <= stat_bad[2] ? ~stat : stat;
    end
endmodule // tfpv_slice_model

// ---- sim/tmr_front_panel_status_voter_bench.sv ----
`timescale 1ns/1ps
`include "tfpv_consts.svh"
module tmr_front_panel_status_voter_bench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, vote_error, fault_reset_req, changeover_req;
    logic chg_event, unlock_pulse, mem_wr_lock, selftest_ok;
    logic [31:0] hrdata, voted_data, la, lb, lc, word = 32'h0, q, w;
    logic [2:0] proc_irq, bad = 3'h0, stat_bad = 3'h0;
    logic [2:0] slice_ok = 3'h7, slice_fatal = 3'h0;
    logic standby_present = 1'b0, seen;
    logic clk_en = 1'b1, cfg_same = 1'b1;
    tfpv_pkg::tfpv_stat_t stat = 8'h00, sa, sb, sc;
    tfpv_pkg::tfpv_sw_t sw = 4'h0;
    tfpv_pkg::tfpv_panel_t panel, p;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int i;
    logic exp_err = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // Short blink and debounce keep the run small
    tfpv_voter #(.BLINK_HALF(4), .DEB_CYC(3)) DUT
    (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .link_data_a(la),
        .link_data_b(lb), .link_data_c(lc), .stat_a(sa), .stat_b(sb),
        .stat_c(sc), .slice_ok(slice_ok), .slice_fatal(slice_fatal),
        .sw_pins(sw), .standby_present(standby_present),
        .standby_cfg_same(cfg_same), .voted_data(voted_data),
        .vote_error(vote_error), .panel(panel), .proc_irq(proc_irq),
        .fault_reset_req(fault_reset_req), .changeover_req(changeover_req),
        .chg_event(chg_event), .unlock_pulse(unlock_pulse),
        .mem_wr_lock(mem_wr_lock), .selftest_ok(selftest_ok)
    );
    tfpv_slice_model slices
    (
        .hclk(hclk), .word(word), .bad(bad), .stat(stat),
        .stat_bad(stat_bad), .data_a(la), .data_b(lb), .data_c(lc),
        .st_a(sa), .st_b(sb), .st_c(sc)
    );
    ////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial
    begin
        forever #5 hclk = ~hclk;
    end
    // Hang guard: far above the few hundred cycles the tests need
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task finish_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task check(input string name, input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // One single AHB-Lite transfer; waits on hready, never on a count
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    // Wait for a one-cycle pulse; each cycle's value is seen exactly once
    task wait_pulse(input int which);
        for (int k = 0; k < 40; k++)
        begin
            seen = (which == 0) ? fault_reset_req : (which == 1) ?
                (proc_irq === 3'h7) : (which == 2) ? unlock_pulse :
                changeover_req;
            if (seen === 1'b1)
                break;
            @(posedge hclk);
        end
    endtask
    function automatic logic [31:0] maj(input logic [31:0] a, b, c);
        return (a & b) | (a & c) | (b & c);
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h5400));
        cyc(20);
        hresetn <= 1'b1;
        for (i = 0; i < 20 && selftest_ok !== 1'b1; i++) @(posedge hclk);
        check("selftest", selftest_ok, 1);
        ahb(0, `TFPV_OFS_STATUS, 0);
        check("test bits", q[5:4], 2'h1);
        ahb(0, 8'h3c, 0);
        check("unmapped", q, 0);
        check("hresp", hresp, 0);
        // Random words; the first two stay clean to see the flag low
        for (i = 0; i < 24; i++)
        begin
            w = $urandom;
            word <= w;
            bad <= (i < 2) ? 3'h0 : 3'(4'h1 << ($urandom % 4) >> 1);
            cyc(1);
            exp_err = exp_err | (bad != 3'h0);
            cyc(3);
            check("voted", voted_data, maj(la, lb, lc));
            check("voted word", voted_data, w);
            check("vote_error", vote_error, exp_err);
        end
        // Enable low: bus stalls and the vote holds its last word
        clk_en <= 1'b0;
        word <= ~w;
        cyc(4);
        check("frozen ready", hreadyout, 0);
        check("frozen vote", voted_data, w);
        clk_en <= 1'b1;
        ahb(0, `TFPV_OFS_STATUS, 0);
        check("status err", q[0], exp_err);
        bad <= 3'h0;
        // Each slice in turn outvoted on the panel status word
        for (i = 0; i < 6; i++)
        begin
            stat <= (i < 3) ? 8'h80 : 8'h00;
            stat_bad <= 3'h1 << (i % 3);
            cyc(5);
            check("active led", panel.active, (i < 3) ? 2'h2 : 2'h0);
        end
        stat <= 8'h80;
        stat_bad <= 3'h0;
        slice_ok <= 3'b110;
        cyc(5);
        check("health0", panel.health[0], 2'h1);
        check("health1", panel.health[1], 2'h2);
        ahb(1, `TFPV_OFS_CTRL, 32'h3);
        cyc(3);
        check("user leds", {panel.user2.red, panel.user1.red}, 2'h3);
        ahb(1, `TFPV_OFS_CTRL, 32'h7);
        wait_pulse(2);
        check("unlock edge", seen, 1);
        ahb(1, `TFPV_OFS_CTRL, 32'h7);
        wait_pulse(2);
        check("unlock level", seen, 0);
        ahb(1, `TFPV_OFS_PARAM, 32'h1234_5678);
        ahb(0, `TFPV_OFS_PARAM, 0);
        check("param rw", q, 32'h1234_5678);
        sw.key_run <= 1'b1;
        cyc(15);
        check("wr lock", mem_wr_lock, 1);
        ahb(1, `TFPV_OFS_PARAM, 32'hffff_0000);
        ahb(0, `TFPV_OFS_PARAM, 0);
        check("param locked", q, 32'h1234_5678);
        ahb(0, `TFPV_OFS_STATUS, 0);
        check("key run", q[6], 1);
        // A one-cycle bounce must be ignored, a held press must not
        sw.btn <= 1'b1;
        cyc(1);
        sw.btn <= 1'b0;
        wait_pulse(0);
        check("bounce", seen, 0);
        sw.btn <= 1'b1;
        wait_pulse(0);
        check("fault reset", seen, 1);
        sw.btn <= 1'b0;
        cyc(3);
        check("err cleared", vote_error, 0);
        ahb(0, `TFPV_OFS_FAULTCNT, 0);
        check("fault count", q, 0);
        ahb(0, `TFPV_OFS_BUTTON, 0);
        check("button", q[0], 1);
        ahb(0, `TFPV_OFS_BUTTON, 0);
        check("button once", q[0], 0);
        sw.latch <= 2'b01;
        wait_pulse(1);
        check("latch irq", seen, 1);
        sw.latch <= 2'b00;
        cyc(15);
        standby_present <= 1'b1;
        sw.latch <= 2'b10;
        wait_pulse(3);
        check("eject chg", seen, 1);
        check("chg event", chg_event, 1);
        sw.latch <= 2'b00;
        cyc(15);
        slice_fatal <= 3'b001;
        wait_pulse(3);
        check("fatal chg", seen, 1);
        ahb(0, `TFPV_OFS_CHGCNT, 0);
        check("chg count", q[15:0], 16'h2);
        // A standby of other configuration refuses the changeover
        slice_fatal <= 3'h0;
        cfg_same <= 1'b0;
        cyc(3);
        slice_fatal <= 3'h1;
        wait_pulse(3);
        check("refused chg", seen, 0);
        p = panel;
        cyc(4);
        check("inhibit", p.inhibit.green ^ panel.inhibit.green, 1);
        check("sys flash", p.sys_ok.red ^ panel.sys_ok.red, 1);
        finish_test();
    end
endmodule // tmr_front_panel_status_voter_bench
